// ===== core/tecs_prescaler.sv
`timescale 1ns/100ps
`include "tecs_defines.svh"

module tecs_prescaler #(
    parameter int CNT_W = 8
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_in,
    input wire logic assign_en,
    input wire logic [2:0] ratio,
    input wire logic clear,
    output logic presc_out
);

    logic prev_reg;
    logic prev_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic out_reg;
    logic out_next;

    // ************************************************************
    // divider chain on rising pin edges
    // ************************************************************
    always_comb
    begin
        prev_next = clk_in;
        cnt_next = cnt_reg;
        if (clear)
        begin
            cnt_next = '0;
        end
        else if (clk_in && !prev_reg)
        begin
            cnt_next = cnt_reg + CNT_W'(1);
        end
        if (assign_en)
        begin
            // a counter bit toggles evenly, so the output is symmetrical
            out_next = cnt_next[ratio];
        end
        else
        begin
            out_next = clk_in;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            prev_reg <= 1'b0;
            cnt_reg <= '0;
            out_reg <= 1'b0;
        end
        else
        begin
            prev_reg <= prev_next;
            cnt_reg <= cnt_next;
            out_reg <= out_next;
        end
    end

    assign presc_out = out_reg;

endmodule : tecs_prescaler

// ===== core/tecs_sync.sv
`timescale 1ns/100ps

module tecs_sync (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic second_phase_clock,
    input wire logic fourth_phase_clock,
    input wire logic timer_edge_select,
    input wire logic presc_in,
    output logic sample,
    output logic inc_pulse
);

    logic sample_reg;
    logic sample_next;
    logic pulse_reg;
    logic pulse_next;
    logic strobe;

    // ************************************************************
    // phase sampling and edge detect
    // ************************************************************
    always_comb
    begin
        strobe = second_phase_clock || fourth_phase_clock;
        sample_next = sample_reg;
        pulse_next = 1'b0;
        if (strobe)
        begin
            sample_next = presc_in;
            // edge select high counts falling edges
            if (timer_edge_select)
            begin
                pulse_next = sample_reg && !presc_in;
            end
            else
            begin
                pulse_next = !sample_reg && presc_in;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            sample_reg <= 1'b0;
            pulse_reg <= 1'b0;
        end
        else
        begin
            sample_reg <= sample_next;
            pulse_reg <= pulse_next;
        end
    end

    assign sample = sample_reg;
    assign inc_pulse = pulse_reg;

endmodule : tecs_sync

// ===== core/tecs_top.sv
`timescale 1ns/100ps
`include "tecs_defines.svh"

module tecs_top #(
    parameter int ADDR_W = 12,
    parameter int PRESC_W = 8
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic shared_port_pin_two_in,
    output logic shared_port_pin_two_out,
    output logic shared_port_pin_two_oe,
    output logic [7:0] timer_zero_counter
);

    // ************************************************************
    // address decode
    // ************************************************************
    function automatic logic [2:0] tecs_decode(input logic [ADDR_W-1:0] addr);
        logic [2:0] sel;
        sel = `TECS_SEL_NONE;
        case (addr)
            `TECS_OFFS_CONFIG: sel = `TECS_SEL_CONFIG;
            `TECS_OFFS_COUNTER: sel = `TECS_SEL_COUNTER;
            `TECS_OFFS_PORT: sel = `TECS_SEL_PORT;
            `TECS_OFFS_STATUS: sel = `TECS_SEL_STATUS;
            default: sel = `TECS_SEL_NONE;
        endcase
        return sel;
    endfunction : tecs_decode

    // ************************************************************
    // pin synchroniser
    // ************************************************************
    logic pin_meta_reg;
    logic pin_sync_reg;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
        end
        else
        begin
            pin_meta_reg <= shared_port_pin_two_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // ************************************************************
    // four-phase generator
    // ************************************************************
    tecs_pkg::tecs_phase_t phase_reg;
    tecs_pkg::tecs_phase_t phase_next;
    logic second_phase_clock;
    logic fourth_phase_clock;

    always_comb
    begin
        case (phase_reg)
            tecs_pkg::TECS_PHASE_1ST: phase_next = tecs_pkg::TECS_PHASE_2ND;
            tecs_pkg::TECS_PHASE_2ND: phase_next = tecs_pkg::TECS_PHASE_3RD;
            tecs_pkg::TECS_PHASE_3RD: phase_next = tecs_pkg::TECS_PHASE_4TH;
            default: phase_next = tecs_pkg::TECS_PHASE_1ST;
        endcase
        second_phase_clock = (phase_reg == tecs_pkg::TECS_PHASE_2ND);
        fourth_phase_clock = (phase_reg == tecs_pkg::TECS_PHASE_4TH);
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            phase_reg <= tecs_pkg::TECS_PHASE_1ST;
        end
        else
        begin
            phase_reg <= phase_next;
        end
    end

    // ************************************************************
    // prescaler and synchroniser
    // ************************************************************
    logic [7:0] cfg_reg;
    logic [7:0] cfg_next;
    logic presc_clear;
    logic presc_out;
    logic sync_sample;
    logic inc_pulse;

    tecs_prescaler #(
        .CNT_W(PRESC_W)
    ) u_prescaler (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clk_in(pin_sync_reg),
        .assign_en(!cfg_reg[`TECS_CFG_PSA_BIT]),
        .ratio(cfg_reg[`TECS_CFG_PS_MSB:`TECS_CFG_PS_LSB]),
        .clear(presc_clear),
        .presc_out(presc_out)
    );

    tecs_sync u_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .second_phase_clock(second_phase_clock),
        .fourth_phase_clock(fourth_phase_clock),
        .timer_edge_select(cfg_reg[`TECS_CFG_EDGE_BIT]),
        .presc_in(presc_out),
        .sample(sync_sample),
        .inc_pulse(inc_pulse)
    );

    // ************************************************************
    // bus slave and registers
    // ************************************************************
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic [1:0] port_reg;
    logic [1:0] port_next;
    logic pin_out_reg;
    logic pin_out_next;
    logic pin_oe_reg;
    logic pin_oe_next;
    logic aw_have_reg;
    logic aw_have_next;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [ADDR_W-1:0] awaddr_next;
    logic w_have_reg;
    logic w_have_next;
    logic [31:0] wdata_reg;
    logic [31:0] wdata_next;
    logic wstrb0_reg;
    logic wstrb0_next;
    logic awready_reg;
    logic awready_next;
    logic wready_reg;
    logic wready_next;
    logic bvalid_reg;
    logic bvalid_next;
    logic [1:0] bresp_reg;
    logic [1:0] bresp_next;
    logic arready_reg;
    logic arready_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0] rresp_reg;
    logic [1:0] rresp_next;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic wr_lane0;
    logic [2:0] wr_sel;
    logic [2:0] rd_sel;
    logic do_write;
    logic pin_forced;

    always_comb
    begin
        cfg_next = cfg_reg;
        cnt_next = cnt_reg;
        port_next = port_reg;
        aw_have_next = aw_have_reg;
        awaddr_next = awaddr_reg;
        w_have_next = w_have_reg;
        wdata_next = wdata_reg;
        wstrb0_next = wstrb0_reg;
        awready_next = awready_reg;
        wready_next = wready_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        arready_next = arready_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        presc_clear = 1'b0;
        pin_forced = cfg_reg[`TECS_CFG_SRC_BIT];
        // readies rise at the first edge after reset
        if (!aw_have_reg && !awready_reg && !bvalid_reg && !w_have_reg && !wready_reg)
        begin
            awready_next = 1'b1;
            wready_next = 1'b1;
        end
        if (!arready_reg && !rvalid_reg)
        begin
            arready_next = 1'b1;
        end

        // counting: pin edges or one step per instruction cycle
        if (cfg_reg[`TECS_CFG_SRC_BIT])
        begin
            if (inc_pulse)
            begin
                cnt_next = cnt_reg + `TECS_COUNT_STEP;
            end
        end
        else if (fourth_phase_clock)
        begin
            cnt_next = cnt_reg + `TECS_COUNT_STEP;
        end

        // write address and data in either order
        if (s_axi_awvalid && awready_reg)
        begin
            aw_have_next = 1'b1;
            awaddr_next = s_axi_awaddr;
            awready_next = 1'b0;
        end
        if (s_axi_wvalid && wready_reg)
        begin
            w_have_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb0_next = s_axi_wstrb[0];
            wready_next = 1'b0;
        end
        wr_addr = awaddr_next;
        wr_data = wdata_next;
        wr_lane0 = wstrb0_next;
        wr_sel = tecs_decode(wr_addr);
        do_write = aw_have_next && w_have_next;
        if (do_write)
        begin
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = (wr_sel == `TECS_SEL_NONE) ? `TECS_RESP_SLVERR : `TECS_RESP_OKAY;
            if (wr_lane0)
            begin
                case (wr_sel)
                    `TECS_SEL_CONFIG: cfg_next = wr_data[7:0];
                    `TECS_SEL_COUNTER:
                    begin
                        // write beats a same-cycle increment
                        cnt_next = wr_data[7:0];
                        presc_clear = !cfg_reg[`TECS_CFG_PSA_BIT];
                    end
                    `TECS_SEL_PORT: port_next = wr_data[1:0];
                    default: presc_clear = 1'b0;
                endcase
            end
        end
        if (bvalid_reg && s_axi_bready)
        begin
            bvalid_next = 1'b0;
            awready_next = 1'b1;
            wready_next = 1'b1;
        end

        // read channel
        rd_sel = tecs_decode(s_axi_araddr);
        if (s_axi_arvalid && arready_reg)
        begin
            arready_next = 1'b0;
            rvalid_next = 1'b1;
            rdata_next = 32'h0000_0000;
            rresp_next = `TECS_RESP_OKAY;
            case (rd_sel)
                `TECS_SEL_CONFIG: rdata_next[7:0] = cfg_reg;
                `TECS_SEL_COUNTER: rdata_next[7:0] = cnt_reg;
                `TECS_SEL_PORT: rdata_next[1:0] = port_reg;
                `TECS_SEL_STATUS:
                begin
                    rdata_next[`TECS_STAT_PIN_BIT] = sync_sample;
                    rdata_next[`TECS_STAT_PRESC_BIT] = presc_out;
                    rdata_next[`TECS_STAT_FORCED_BIT] = pin_forced;
                end
                default: rresp_next = `TECS_RESP_SLVERR;
            endcase
        end
        else if (rvalid_reg && s_axi_rready)
        begin
            rvalid_next = 1'b0;
            arready_next = 1'b1;
        end

        // pin drive: source select overrides the direction latch
        pin_out_next = port_reg[`TECS_PORT_DATA_BIT];
        pin_oe_next = !pin_forced && !port_reg[`TECS_PORT_DIR_BIT];
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            cfg_reg <= `TECS_CFG_RESET;
            cnt_reg <= `TECS_COUNT_RESET;
            port_reg <= `TECS_PORT_RESET;
            pin_out_reg <= 1'b0;
            pin_oe_reg <= 1'b0;
            aw_have_reg <= 1'b0;
            awaddr_reg <= '0;
            w_have_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb0_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `TECS_RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `TECS_RESP_OKAY;
        end
        else
        begin
            cfg_reg <= cfg_next;
            cnt_reg <= cnt_next;
            port_reg <= port_next;
            pin_out_reg <= pin_out_next;
            pin_oe_reg <= pin_oe_next;
            aw_have_reg <= aw_have_next;
            awaddr_reg <= awaddr_next;
            w_have_reg <= w_have_next;
            wdata_reg <= wdata_next;
            wstrb0_reg <= wstrb0_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign shared_port_pin_two_out = pin_out_reg;
    assign shared_port_pin_two_oe = pin_oe_reg;
    assign timer_zero_counter = cnt_reg;

endmodule : tecs_top

// ===== inc/tecs_defines.svh
`ifndef TECS_DEFINES_SVH
`define TECS_DEFINES_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define TECS_OFFS_CONFIG 12'h000
`define TECS_OFFS_COUNTER 12'h004
`define TECS_OFFS_PORT 12'h008
`define TECS_OFFS_STATUS 12'h00c

// ************************************************************
// register select codes
// ************************************************************
`define TECS_SEL_NONE 3'h0
`define TECS_SEL_CONFIG 3'h1
`define TECS_SEL_COUNTER 3'h2
`define TECS_SEL_PORT 3'h3
`define TECS_SEL_STATUS 3'h4

// ************************************************************
// configuration fields and reset value
// ************************************************************
`define TECS_CFG_SRC_BIT 5
`define TECS_CFG_EDGE_BIT 4
`define TECS_CFG_PSA_BIT 3
`define TECS_CFG_PS_MSB 2
`define TECS_CFG_PS_LSB 0
`define TECS_CFG_RESET 8'hff

// ************************************************************
// port register fields and reset value
// ************************************************************
`define TECS_PORT_DIR_BIT 0
`define TECS_PORT_DATA_BIT 1
`define TECS_PORT_RESET 2'h1

// ************************************************************
// status fields
// ************************************************************
`define TECS_STAT_PIN_BIT 0
`define TECS_STAT_PRESC_BIT 1
`define TECS_STAT_FORCED_BIT 2

// ************************************************************
// bus answers and misc
// ************************************************************
`define TECS_RESP_OKAY 2'h0
`define TECS_RESP_SLVERR 2'h2
`define TECS_COUNT_RESET 8'h00
`define TECS_COUNT_STEP 8'h01

`endif

// ===== inc/tecs_pkg.sv
package tecs_pkg;

    // four phases of one instruction cycle
    typedef enum logic [1:0] {
        TECS_PHASE_1ST,
        TECS_PHASE_2ND,
        TECS_PHASE_3RD,
        TECS_PHASE_4TH
    } tecs_phase_t;

endpackage : tecs_pkg

// ===== testbench/tecs_pin_src.sv
`timescale 1ns/100ps

module tecs_pin_src (
    input wire logic sys_clk,
    output logic pin
);
    initial pin = 1'b0;

    // ********
    // pulse bursts, pin idles low
    // ********
    task automatic pulses(input int n, input int half);
        repeat (n)
        begin
            @(posedge sys_clk);
            pin <= 1'b1;
            repeat (half) @(posedge sys_clk);
            pin <= 1'b0;
            repeat (half - 1) @(posedge sys_clk);
        end
    endtask : pulses

    task automatic level(input logic v);
        @(posedge sys_clk);
        pin <= v;
    endtask : level
endmodule : tecs_pin_src

// ===== testbench/tecs_top_asserts.sv
`timescale 1ns/100ps
`include "tecs_defines.svh"

module tecs_chk #(
    parameter int ADDR_W = 12
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic shared_port_pin_two_in,
    input wire logic shared_port_pin_two_oe,
    input wire logic [7:0] timer_zero_counter
);
    // ********
    // shadow of config and port direction
    // ********
    logic [7:0] cfg_reg, cfg_next;
    logic dir_reg, dir_next;
    logic wr_go, oe_exp, pin_mode, int_mode;
    assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign oe_exp = !cfg_reg[5] && !dir_reg;
    assign pin_mode = cfg_reg[5] && cfg_reg[4] && cfg_reg[3];
    assign int_mode = !cfg_reg[5];
    always_comb
    begin
        cfg_next = cfg_reg;
        dir_next = dir_reg;
        if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == `TECS_OFFS_CONFIG)
            cfg_next = s_axi_wdata[7:0];
        if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == `TECS_OFFS_PORT)
            dir_next = s_axi_wdata[0];
    end
    always_ff @(posedge sys_clk)
    begin
        cfg_reg <= sys_rst ? `TECS_CFG_RESET : cfg_next;
        dir_reg <= sys_rst ? 1'b1 : dir_next;
    end

    // ********
    // properties
    // ********
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence s_quiet2;
        $stable(timer_zero_counter) [*2];
    endsequence
    sequence s_hold3;
        $stable(timer_zero_counter) [*3];
    endsequence
    property p_wr_resp;
        wr_go |=> s_axi_bvalid && !s_axi_awready;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write not answered");
    property p_b_clear;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_clear: assert property (p_b_clear) else $error("bvalid stuck");
    property p_bad_wr;
        wr_go && s_axi_awaddr > 12'h00c |=> s_axi_bresp == `TECS_RESP_SLVERR;
    endproperty
    a_bad_wr: assert property (p_bad_wr) else $error("unmapped write not refused");
    property p_rd_resp;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("read not answered");
    property p_bad_rd;
        s_axi_arvalid && s_axi_arready && s_axi_araddr > 12'h00c
            |=> s_axi_rdata == 32'h0 && s_axi_rresp == `TECS_RESP_SLVERR;
    endproperty
    a_bad_rd: assert property (p_bad_rd) else $error("unmapped read not refused");
    property p_oe_forced;
        shared_port_pin_two_oe == $past(oe_exp);
    endproperty
    a_oe_forced: assert property (p_oe_forced) else $error("pin enable wrong");
    property p_cnt_step;
        !wr_go |=> timer_zero_counter == $past(timer_zero_counter)
            || timer_zero_counter == $past(timer_zero_counter) + 8'h01;
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("counter jumped");
    property p_pin_lat;
        $fell(shared_port_pin_two_in) && pin_mode |=> s_quiet2 ##[1:6] !$stable(timer_zero_counter);
    endproperty
    a_pin_lat: assert property (p_pin_lat) else $error("pin edge latency wrong");
    property p_int_step;
        int_mode && !$stable(timer_zero_counter) |=> s_hold3 ##1 !$stable(timer_zero_counter);
    endproperty
    a_int_step: assert property (p_int_step) else $error("phase cadence wrong");
endmodule : tecs_chk

bind tecs_top tecs_chk #(.ADDR_W(ADDR_W)) chk_u (.sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .shared_port_pin_two_in, .shared_port_pin_two_oe, .timer_zero_counter);

// ===== testbench/testbench.sv
`timescale 1ns/100ps
`include "tecs_defines.svh"

module testbench;
    logic sys_clk = 1'b0, sys_rst = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic src_pin, shared_port_pin_two_in, shared_port_pin_two_out, shared_port_pin_two_oe;
    logic [7:0] timer_zero_counter;
    int n_errors = 0;
    int tests_run = 0;

    always #5 sys_clk = ~sys_clk;
    assign shared_port_pin_two_in = shared_port_pin_two_oe ? shared_port_pin_two_out : src_pin;

    tecs_top dut_u (.sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .shared_port_pin_two_in, .shared_port_pin_two_out,
        .shared_port_pin_two_oe, .timer_zero_counter);
    tecs_pin_src src_u (.sys_clk, .pin(src_pin));

    // ********
    // helpers
    // ********
    task automatic final_report;
        if (n_errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        logic aw_pend, w_pend;
        aw_pend = 1'b1;
        w_pend = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw_pend || w_pend)
        begin
            @(posedge sys_clk);
            if (aw_pend && s_axi_awready)
            begin
                aw_pend = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_pend && s_axi_wready)
            begin
                w_pend = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge sys_clk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge sys_clk);
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge sys_clk);
    endtask : axi_read

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [1:0] r;
        axi_write(a, {24'h0, d}, 4'hf, r);
        chk({30'h0, r}, {30'h0, `TECS_RESP_OKAY}, "write response");
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er, input string what);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        chk({30'h0, r}, {30'h0, er}, what);
        chk(d, exp, what);
    endtask : rd_chk

    // ********
    // scenarios
    // ********
    task automatic t_regs;
        logic [1:0] r;
        rd_chk(`TECS_OFFS_CONFIG, 32'hff, `TECS_RESP_OKAY, "config reset");
        rd_chk(`TECS_OFFS_PORT, 32'h1, `TECS_RESP_OKAY, "port reset");
        rd_chk(`TECS_OFFS_COUNTER, 32'h0, `TECS_RESP_OKAY, "counter reset");
        wr(`TECS_OFFS_CONFIG, 8'hea);
        rd_chk(`TECS_OFFS_CONFIG, 32'hea, `TECS_RESP_OKAY, "config fields");
        wr(`TECS_OFFS_CONFIG, 8'hff);
        axi_write(`TECS_OFFS_CONFIG, 32'h00, 4'he, r);
        chk({30'h0, r}, {30'h0, `TECS_RESP_OKAY}, "masked write response");
        rd_chk(`TECS_OFFS_CONFIG, 32'hff, `TECS_RESP_OKAY, "masked write ignored");
        axi_write(12'h010, 32'h5a, 4'hf, r);
        chk({30'h0, r}, {30'h0, `TECS_RESP_SLVERR}, "unmapped write");
        rd_chk(12'h010, 32'h0, `TECS_RESP_SLVERR, "unmapped read");
    endtask : t_regs

    task automatic t_pass;
        src_u.level(1'b1);
        repeat (8) @(posedge sys_clk);
        rd_chk(`TECS_OFFS_STATUS, 32'h7, `TECS_RESP_OKAY, "pin high through");
        src_u.level(1'b0);
        repeat (8) @(posedge sys_clk);
        rd_chk(`TECS_OFFS_STATUS, 32'h4, `TECS_RESP_OKAY, "pin low through");
    endtask : t_pass

    task automatic t_count;
        wr(`TECS_OFFS_COUNTER, 8'hfe);
        src_u.pulses(3, 3);
        repeat (12) @(posedge sys_clk);
        rd_chk(`TECS_OFFS_COUNTER, 32'h1, `TECS_RESP_OKAY, "pin count wrap");
    endtask : t_count

    task automatic t_presc;
        logic [7:0] cfg;
        for (int r = 0; r < 8; r++)
        begin
            cfg = {3'b001, r[0], 1'b0, r[2:0]};
            wr(`TECS_OFFS_CONFIG, cfg);
            wr(`TECS_OFFS_COUNTER, 8'h00);
            src_u.pulses((1 << r) - 1, 3);
            repeat (12) @(posedge sys_clk);
            wr(`TECS_OFFS_COUNTER, 8'h00);
            src_u.pulses((6 << r) - 1, 3);
            repeat (12) @(posedge sys_clk);
            rd_chk(`TECS_OFFS_COUNTER, r[0] ? 32'h2 : 32'h3, `TECS_RESP_OKAY, "divided count");
        end
        wr(`TECS_OFFS_CONFIG, 8'hff);
    endtask : t_presc

    task automatic t_force;
        wr(`TECS_OFFS_PORT, 8'h02);
        repeat (3) @(posedge sys_clk);
        chk({30'h0, shared_port_pin_two_oe, shared_port_pin_two_out}, 32'h1, "pin not forced");
        wr(`TECS_OFFS_CONFIG, 8'hdf);
        repeat (3) @(posedge sys_clk);
        chk({30'h0, shared_port_pin_two_oe, shared_port_pin_two_out}, 32'h3, "pin not released");
        repeat (40) @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rd_chk(`TECS_OFFS_CONFIG, 32'hff, `TECS_RESP_OKAY, "config after reset");
    endtask : t_force

    initial
    begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        t_regs;
        t_pass;
        t_count;
        t_presc;
        t_force;
        final_report;
    end

    initial
    begin
        #400000;
        n_errors++;
        final_report;
    end
endmodule : testbench
